/* rtc_ident_regs.svh */
// Register offsets, field positions, reset values and rule summary for the identity block
// Operation
// - Upper part number holds two BCD digits
// - Lower part number holds remaining BCD digits
// - Revision: major bits 7-3, minor 2-0
// - Lot register returns lot bits 7-0
// - Lot bit 9 in upper identifier bit 7
// - 15-bit unique identifier across two registers
// - Wafer register: lot bit 8, wafer, reserved
// - Clock-out pin driven on battery when set
// - Polarity selects below or above threshold
// - Bit 5 reads watchdog pin level
// - Bit 4 reads external interrupt pin level
// - Standard window address from page bits
// - Alternate window address from page bit
// - Standard window works in both modes
// - Alternate window reachable only over I2C
// - RAM contents kept on battery
// - RAM has no defined power-up value
// - Threshold select field in control bits 7-4
`ifndef RTC_IDENT_REGS_SVH
`define RTC_IDENT_REGS_SVH

// ==========================================
// Register offsets
`define OFS_PART_HI 8'h28
`define OFS_PART_LO 8'h29
`define OFS_REVISION 8'h2A
`define OFS_LOT_LOW 8'h2B
`define OFS_SERIAL_HI 8'h2C
`define OFS_SERIAL_LO 8'h2D
`define OFS_WAFER 8'h2E
`define OFS_RAM_PAGE 8'h3F
`define OFS_THRESH_CTRL 8'h21
`define OFS_STD_FIRST 8'h40
`define OFS_STD_LAST 8'h7F
`define OFS_ALT_FIRST 8'h80

// ==========================================
// Field positions and widths
`define STD_OFS_BITS 6
`define ALT_OFS_BITS 7
`define THRESH_LSB 4
`define REV_MAJOR_LSB 3
`define LOT_BIT8 8
`define LOT_BIT9 9
`define SERIAL_SPLIT 8
`define WAFER_LSB 2
`define SERIAL_MSB 14
`define LOT_LOW_MSB 7
// Page register bits that a write can store
`define PAGE_WR_MASK 8'hC7
// Reserved fields that always read zero
`define RSVD_NIBBLE 4'h0
`define WAFER_RSVD 2'b00

// ==========================================
// Reset values
`define RAM_PAGE_RESET 8'h00
`define THRESH_RESET 4'hF
`define BYTE_ZERO 8'h00

`endif

/* rtc_ident_pkg.sv */
// Types shared by the identity and RAM window block
package rtc_ident_pkg;

  // ==========================================
  // Access request from the serial interface engine
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acc_req_s;

  // ==========================================
  // Page and miscellaneous control register layout
  typedef struct packed {
    logic clkout_battery_enable;
    logic battery_low_polarity;
    logic watchdog_pin_level;
    logic ext_irq_pin_level;
    logic reserved;
    logic alt_ram_page_bit;
    logic [1:0] std_ram_page_bits;
  } ram_page_s;

  // ==========================================
  // Decoded target of an access
  typedef enum logic [2:0] {
    WIN_NONE = 3'b000,
    WIN_IDENT = 3'b001,
    WIN_PAGE = 3'b010,
    WIN_STD = 3'b011,
    WIN_ALT = 3'b100,
    WIN_THRESH = 3'b101
  } window_e;

endpackage : rtc_ident_pkg

/* rtc_user_ram.sv */
// User RAM array, 256 bytes, contents undefined at power-up
`timescale 1ns/100ps
module rtc_user_ram (
  // Clock
  input wire logic ref_clk,
  // Write port
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);

  // Array is never cleared so contents survive any reset
  logic [7:0] mem [0:255];

  // ==========================================
  // Write
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ==========================================
  // Read, registered by the caller
  assign rd_data = mem[rd_addr];

endmodule : rtc_user_ram

/* rtc_ident_block.sv */
// Identity registers, RAM page register and RAM windows
`timescale 1ns/100ps
`include "rtc_ident_regs.svh"
module rtc_ident_block #(
  // Factory values; defaults are arbitrary
  parameter logic [7:0] PART_HI = 8'h42,
  parameter logic [7:0] PART_LO = 8'h15,
  parameter logic [4:0] REV_MAJOR = 5'h02,
  parameter logic [2:0] REV_MINOR = 3'h3,
  parameter logic [9:0] LOT_NUMBER = 10'h2A5,
  parameter logic [14:0] UNIQUE_ID = 15'h1234,
  parameter logic [4:0] WAFER_NUMBER = 5'h0B
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register access from the serial engine
  input wire rtc_ident_pkg::acc_req_s acc_req,
  input wire logic if_mode_spi,
  output logic [7:0] acc_rdata,
  output logic acc_rvalid,
  // Pins and analog status
  input wire logic watchdog_input_pin,
  input wire logic external_interrupt_pin,
  input wire logic on_battery,
  input wire logic vbat_above_ref,
  // Battery low flag handling
  input wire logic battery_low_clear,
  output logic battery_low_flag,
  output logic [3:0] battery_threshold_select,
  // Clock output / third interrupt pin
  input wire logic clock_out_irq3_src,
  output logic clock_out_irq3_pin_o,
  output logic clock_out_irq3_pin_oe
);

  // ==========================================
  // Fixed identity bytes
  localparam logic [7:0] REV_BYTE = {REV_MAJOR, REV_MINOR};
  localparam logic [7:0] SERIAL_HI_BYTE =
    {LOT_NUMBER[`LOT_BIT9], UNIQUE_ID[`SERIAL_MSB:`SERIAL_SPLIT]};
  localparam logic [7:0] WAFER_BYTE =
    {LOT_NUMBER[`LOT_BIT8], WAFER_NUMBER, `WAFER_RSVD};

  rtc_ident_pkg::ram_page_s page;
  rtc_ident_pkg::window_e win;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic wd_lvl;
  logic ex_lvl;
  logic batt_lvl;
  logic above_lvl;
  logic [7:0] ram_addr;
  logic [7:0] ram_q;
  logic ram_we;
  logic [7:0] ident_byte;
  logic [7:0] page_byte;
  logic [7:0] next_rdata;
  logic low_cond;

  // ==========================================
  // Two-flop synchronisers for pin and analog levels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {vbat_above_ref, on_battery, external_interrupt_pin, watchdog_input_pin};
      sync_b <= sync_a;
    end
  end

  assign wd_lvl = sync_b[0];
  assign ex_lvl = sync_b[1];
  assign batt_lvl = sync_b[2];
  assign above_lvl = sync_b[3];

  // ==========================================
  // Address decode
  always_comb begin
    win = rtc_ident_pkg::WIN_NONE;
    ram_addr = `BYTE_ZERO;
    if (acc_req.addr >= `OFS_ALT_FIRST) begin
      win = rtc_ident_pkg::WIN_ALT;
      ram_addr = {page.alt_ram_page_bit, acc_req.addr[`ALT_OFS_BITS-1:0]};
    end else if (acc_req.addr >= `OFS_STD_FIRST) begin
      win = rtc_ident_pkg::WIN_STD;
      ram_addr = {page.std_ram_page_bits, acc_req.addr[`STD_OFS_BITS-1:0]};
    end else if (acc_req.addr == `OFS_RAM_PAGE) begin
      win = rtc_ident_pkg::WIN_PAGE;
    end else if (acc_req.addr == `OFS_THRESH_CTRL) begin
      win = rtc_ident_pkg::WIN_THRESH;
    end else if (acc_req.addr >= `OFS_PART_HI && acc_req.addr <= `OFS_WAFER) begin
      win = rtc_ident_pkg::WIN_IDENT;
    end
  end

  // ==========================================
  // Identity byte select, constants only
  always_comb begin
    ident_byte = `BYTE_ZERO;
    if (acc_req.addr == `OFS_PART_HI) begin
      ident_byte = PART_HI;
    end else if (acc_req.addr == `OFS_PART_LO) begin
      ident_byte = PART_LO;
    end else if (acc_req.addr == `OFS_REVISION) begin
      ident_byte = REV_BYTE;
    end else if (acc_req.addr == `OFS_LOT_LOW) begin
      ident_byte = LOT_NUMBER[`LOT_LOW_MSB:0];
    end else if (acc_req.addr == `OFS_SERIAL_HI) begin
      ident_byte = SERIAL_HI_BYTE;
    end else if (acc_req.addr == `OFS_SERIAL_LO) begin
      ident_byte = UNIQUE_ID[`SERIAL_SPLIT-1:0];
    end else if (acc_req.addr == `OFS_WAFER) begin
      ident_byte = WAFER_BYTE;
    end
  end

  // Page register view with live pin levels, reserved bit zero
  always_comb begin
    page_byte = {page.clkout_battery_enable, page.battery_low_polarity, wd_lvl, ex_lvl,
      1'b0, page.alt_ram_page_bit, page.std_ram_page_bits};
  end

  // ==========================================
  // Page register writes; identity writes fall through
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      page <= `RAM_PAGE_RESET;
    end else if (acc_req.valid && acc_req.write && win == rtc_ident_pkg::WIN_PAGE) begin
      page <= acc_req.wdata & `PAGE_WR_MASK;
    end
  end

  // Threshold select control bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_threshold_select <= `THRESH_RESET;
    end else if (acc_req.valid && acc_req.write && win == rtc_ident_pkg::WIN_THRESH) begin
      battery_threshold_select <= acc_req.wdata[7:`THRESH_LSB];
    end
  end

  // ==========================================
  // RAM window; alternate window closed in SPI mode
  assign ram_we = acc_req.valid && acc_req.write &&
    (win == rtc_ident_pkg::WIN_STD ||
     (win == rtc_ident_pkg::WIN_ALT && !if_mode_spi));

  rtc_user_ram u_ram (
    .ref_clk(ref_clk),
    .wr_en(ram_we),
    .wr_addr(ram_addr),
    .wr_data(acc_req.wdata),
    .rd_addr(ram_addr),
    .rd_data(ram_q)
  );

  // ==========================================
  // Read data select
  always_comb begin
    next_rdata = `BYTE_ZERO;
    case (win)
      rtc_ident_pkg::WIN_IDENT: next_rdata = ident_byte;
      rtc_ident_pkg::WIN_PAGE: next_rdata = page_byte;
      rtc_ident_pkg::WIN_THRESH: next_rdata = {battery_threshold_select, `RSVD_NIBBLE};
      rtc_ident_pkg::WIN_STD: next_rdata = ram_q;
      rtc_ident_pkg::WIN_ALT: next_rdata = if_mode_spi ? `BYTE_ZERO : ram_q;
      default: next_rdata = `BYTE_ZERO;
    endcase
  end

  // Read answer one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_rdata <= `BYTE_ZERO;
      acc_rvalid <= 1'b0;
    end else begin
      acc_rvalid <= acc_req.valid && !acc_req.write;
      if (acc_req.valid && !acc_req.write) begin
        acc_rdata <= next_rdata;
      end
    end
  end

  // ==========================================
  // Battery low flag, set wins over clear
  assign low_cond = page.battery_low_polarity ? above_lvl : !above_lvl;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_low_flag <= 1'b0;
    end else if (low_cond) begin
      battery_low_flag <= 1'b1;
    end else if (battery_low_clear) begin
      battery_low_flag <= 1'b0;
    end
  end

  // ==========================================
  // Clock-out pin gating on battery power
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_out_irq3_pin_o <= 1'b1;
      clock_out_irq3_pin_oe <= 1'b0;
    end else begin
      clock_out_irq3_pin_o <= clock_out_irq3_src;
      clock_out_irq3_pin_oe <= !batt_lvl || page.clkout_battery_enable;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_part_hi;
    acc_req.valid && !acc_req.write && acc_req.addr == `OFS_PART_HI
      |=> acc_rvalid && acc_rdata == PART_HI;
  endproperty
  a_part_hi: assert property (p_part_hi) else $error("part number high wrong");

  property p_part_lo;
    acc_req.valid && !acc_req.write && acc_req.addr == `OFS_PART_LO
      |=> acc_rvalid && acc_rdata == PART_LO;
  endproperty
  a_part_lo: assert property (p_part_lo) else $error("part number low wrong");

  property p_lot_low;
    acc_req.valid && !acc_req.write && acc_req.addr == `OFS_LOT_LOW
      |=> acc_rvalid && acc_rdata == LOT_NUMBER[`LOT_LOW_MSB:0];
  endproperty
  a_lot_low: assert property (p_lot_low) else $error("lot low byte wrong");

  property p_serial_lo;
    acc_req.valid && !acc_req.write && acc_req.addr == `OFS_SERIAL_LO
      |=> acc_rvalid && acc_rdata == UNIQUE_ID[`SERIAL_SPLIT-1:0];
  endproperty
  a_serial_lo: assert property (p_serial_lo) else $error("lower identifier wrong");

  property p_rev;
    acc_req.valid && !acc_req.write && acc_req.addr == `OFS_REVISION
      |=> acc_rdata[7:`REV_MAJOR_LSB] == REV_MAJOR && acc_rdata[2:0] == REV_MINOR;
  endproperty
  a_rev: assert property (p_rev) else $error("revision fields wrong");

  property p_serial_hi;
    acc_req.valid && !acc_req.write && acc_req.addr == `OFS_SERIAL_HI
      |=> acc_rdata[7] == LOT_NUMBER[`LOT_BIT9] && acc_rdata[6:0] == UNIQUE_ID[14:8];
  endproperty
  a_serial_hi: assert property (p_serial_hi) else $error("upper identifier wrong");

  property p_wafer;
    acc_req.valid && !acc_req.write && acc_req.addr == `OFS_WAFER
      |=> acc_rdata[6:`WAFER_LSB] == WAFER_NUMBER && acc_rdata[1:0] == 2'b00;
  endproperty
  a_wafer: assert property (p_wafer) else $error("wafer register wrong");

  property p_wd_level;
    acc_req.valid && !acc_req.write && acc_req.addr == `OFS_RAM_PAGE
      |=> acc_rdata[5] == $past(wd_lvl) && acc_rdata[3] == 1'b0;
  endproperty
  a_wd_level: assert property (p_wd_level) else $error("watchdog level wrong");

  property p_ext_level;
    acc_req.valid && !acc_req.write && acc_req.addr == `OFS_RAM_PAGE
      |=> acc_rdata[4] == $past(ex_lvl);
  endproperty
  a_ext_level: assert property (p_ext_level) else $error("interrupt pin level wrong");

  property p_clkout_off;
    batt_lvl && !page.clkout_battery_enable |=> !clock_out_irq3_pin_oe;
  endproperty
  a_clkout_off: assert property (p_clkout_off) else $error("pin driven on battery");

  property p_low_set;
    page.battery_low_polarity && above_lvl |=> battery_low_flag;
  endproperty
  a_low_set: assert property (p_low_set) else $error("battery low not set");

  property p_low_set_below;
    !page.battery_low_polarity && !above_lvl |=> battery_low_flag;
  endproperty
  a_low_set_below: assert property (p_low_set_below) else $error("low flag not set below");

  property p_std_addr;
    win == rtc_ident_pkg::WIN_STD |-> ram_addr[7:6] == page.std_ram_page_bits;
  endproperty
  a_std_addr: assert property (p_std_addr) else $error("standard page wrong");

  property p_std_write;
    acc_req.valid && acc_req.write && win == rtc_ident_pkg::WIN_STD |-> ram_we;
  endproperty
  a_std_write: assert property (p_std_write) else $error("standard write dropped");

  property p_std_read;
    acc_req.valid && !acc_req.write && win == rtc_ident_pkg::WIN_STD
      |=> acc_rvalid && acc_rdata == $past(ram_q);
  endproperty
  a_std_read: assert property (p_std_read) else $error("standard read data wrong");

  property p_alt_spi;
    if_mode_spi && win == rtc_ident_pkg::WIN_ALT |-> !ram_we;
  endproperty
  a_alt_spi: assert property (p_alt_spi) else $error("alternate write in SPI");

  property p_alt_spi_read;
    acc_req.valid && !acc_req.write && if_mode_spi && win == rtc_ident_pkg::WIN_ALT
      |=> acc_rvalid && acc_rdata == `BYTE_ZERO;
  endproperty
  a_alt_spi_read: assert property (p_alt_spi_read) else $error("alternate read in SPI");

  property p_ident_ro;
    acc_req.valid && acc_req.write && win == rtc_ident_pkg::WIN_IDENT |=> $stable(page);
  endproperty
  a_ident_ro: assert property (p_ident_ro) else $error("identity write had effect");

  c_std_write: cover property (ram_we && win == rtc_ident_pkg::WIN_STD);
  c_alt_read: cover property (acc_rvalid && $past(win) == rtc_ident_pkg::WIN_ALT);
  c_page_write: cover property (acc_req.valid && acc_req.write && win == rtc_ident_pkg::WIN_PAGE);

endmodule : rtc_ident_block

/* host_model.sv */
// Host side model issuing single-byte register accesses to the block
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic ref_clk,
  // Access port toward the block
  output rtc_ident_pkg::acc_req_s acc_req,
  output logic if_mode_spi,
  // Read answer from the block
  input wire logic [7:0] acc_rdata,
  input wire logic acc_rvalid
);
  // ==========================================
  // Idle state: no request, I2C mode
  initial begin
    acc_req = '0;
    if_mode_spi = 1'b0;
  end

  // Released fields show the inverse of the last value, so stale data never passes
  task automatic release_bus;
    acc_req.valid = 1'b0;
    acc_req.addr = ~acc_req.addr;
    acc_req.wdata = ~acc_req.wdata;
  endtask : release_bus

  // ==========================================
  // Write: request held across one rising edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk);
    acc_req.valid = 1'b1;
    acc_req.write = 1'b1;
    acc_req.addr = addr;
    acc_req.wdata = data;
    @(negedge ref_clk);
    release_bus();
  endtask : wr

  // Read: wait a bounded number of cycles for the answer pulse
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(negedge ref_clk);
    acc_req.valid = 1'b1;
    acc_req.write = 1'b0;
    acc_req.addr = addr;
    @(negedge ref_clk);
    release_bus();
    ok = 1'b0;
    data = 8'h00;
    for (int i = 0; i < 3 && !ok; i++) begin
      if (acc_rvalid === 1'b1) begin
        data = acc_rdata;
        ok = 1'b1;
      end else begin
        @(negedge ref_clk);
      end
    end
  endtask : rd

  // Interface mode changes only between accesses
  task automatic set_mode(input logic spi);
    @(negedge ref_clk);
    if_mode_spi = spi;
  endtask : set_mode
endmodule : host_model

/* tb_top.sv */
// Self-checking bench for the identity registers and RAM windows
`timescale 1ns/100ps
`include "rtc_ident_regs.svh"
module tb_top;
  // ==========================================
  // Factory values handed to the block
  localparam logic [7:0] P_PART_HI = 8'h56;
  localparam logic [7:0] P_PART_LO = 8'h31;
  localparam logic [4:0] P_REV_MAJOR = 5'h11;
  localparam logic [2:0] P_REV_MINOR = 3'h5;
  localparam logic [9:0] P_LOT = 10'h3C9;
  localparam logic [14:0] P_UID = 15'h5A3C;
  localparam logic [4:0] P_WAFER = 5'h17;

  // ==========================================
  // Signals
  logic ref_clk, rst_n, watchdog_input_pin, external_interrupt_pin;
  logic on_battery, vbat_above_ref, battery_low_clear, clock_out_irq3_src;
  rtc_ident_pkg::acc_req_s acc_req;
  logic if_mode_spi, acc_rvalid, battery_low_flag;
  logic clock_out_irq3_pin_o, clock_out_irq3_pin_oe;
  logic [7:0] acc_rdata;
  logic [3:0] battery_threshold_select;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Device under test
  rtc_ident_block #(.PART_HI(P_PART_HI), .PART_LO(P_PART_LO), .REV_MAJOR(P_REV_MAJOR),
    .REV_MINOR(P_REV_MINOR), .LOT_NUMBER(P_LOT), .UNIQUE_ID(P_UID),
    .WAFER_NUMBER(P_WAFER)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .acc_req(acc_req), .if_mode_spi(if_mode_spi),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
    .watchdog_input_pin(watchdog_input_pin), .external_interrupt_pin(external_interrupt_pin),
    .on_battery(on_battery), .vbat_above_ref(vbat_above_ref),
    .battery_low_clear(battery_low_clear), .battery_low_flag(battery_low_flag),
    .battery_threshold_select(battery_threshold_select),
    .clock_out_irq3_src(clock_out_irq3_src), .clock_out_irq3_pin_o(clock_out_irq3_pin_o),
    .clock_out_irq3_pin_oe(clock_out_irq3_pin_oe));

  // Host partner
  host_model i_host (.ref_clk(ref_clk), .acc_req(acc_req), .if_mode_spi(if_mode_spi),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));

  // ==========================================
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("ERROR at %0t: run took too long", $time);
      results();
    end
  end

  // ==========================================
  // Compare and helper tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    logic ok;
    i_host.rd(addr, got, ok);
    if (!ok) got = 8'hXX;
    chk8(got, exp, $sformatf("read %h", addr));
  endtask : rdchk

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_cyc

  task automatic pulse_clear;
    battery_low_clear = 1'b1;
    @(negedge ref_clk);
    battery_low_clear = 1'b0;
    @(negedge ref_clk);
  endtask : pulse_clear

  // ==========================================
  // Scenarios
  task automatic t_ident;
    logic [7:0] exp [7] = '{P_PART_HI, P_PART_LO, {P_REV_MAJOR, P_REV_MINOR}, P_LOT[7:0],
      {P_LOT[9], P_UID[14:8]}, P_UID[7:0], {P_LOT[8], P_WAFER, 2'b00}};
    for (int i = 0; i < 7; i++) begin
      rdchk(`OFS_PART_HI + 8'(i), exp[i]);
      i_host.wr(`OFS_PART_HI + 8'(i), ~exp[i]);
      rdchk(`OFS_PART_HI + 8'(i), exp[i]);
    end
    rdchk(8'h30, 8'h00);
    $display("test ident done");
  endtask : t_ident

  task automatic t_page;
    rdchk(`OFS_RAM_PAGE, 8'h00);
    i_host.wr(`OFS_RAM_PAGE, 8'hFF);
    rdchk(`OFS_RAM_PAGE, 8'hC7);
    watchdog_input_pin = 1'b1;
    wait_cyc(4);
    rdchk(`OFS_RAM_PAGE, 8'hE7);
    watchdog_input_pin = 1'b0;
    external_interrupt_pin = 1'b1;
    wait_cyc(4);
    rdchk(`OFS_RAM_PAGE, 8'hD7);
    external_interrupt_pin = 1'b0;
    $display("test page done");
  endtask : t_page

  task automatic t_ram;
    logic [7:0] ofs;
    for (int p = 0; p < 4; p++) begin
      ofs = 8'(p * 9 + 3);
      i_host.wr(`OFS_RAM_PAGE, 8'(p));
      i_host.wr(`OFS_STD_FIRST | ofs, 8'hA0 + 8'(p));
    end
    for (int p = 0; p < 4; p++) begin
      ofs = 8'(p * 9 + 3);
      i_host.wr(`OFS_RAM_PAGE, {5'b0, p[1], 2'b00});
      rdchk(`OFS_ALT_FIRST | {1'b0, p[0], ofs[5:0]}, 8'hA0 + 8'(p));
    end
    i_host.set_mode(1'b1);
    i_host.wr(`OFS_RAM_PAGE, 8'h00);
    rdchk(`OFS_STD_FIRST | 8'h03, 8'hA0);
    rdchk(`OFS_ALT_FIRST | 8'h03, 8'h00);
    i_host.wr(`OFS_ALT_FIRST | 8'h03, 8'h55);
    i_host.set_mode(1'b0);
    rdchk(`OFS_ALT_FIRST | 8'h03, 8'hA0);
    $display("test ram done");
  endtask : t_ram

  task automatic t_pin;
    clock_out_irq3_src = 1'b0;
    wait_cyc(3);
    chk1(clock_out_irq3_pin_oe, 1'b1, "pin enable on main supply");
    chk1(clock_out_irq3_pin_o, 1'b0, "pin value");
    on_battery = 1'b1;
    wait_cyc(4);
    chk1(clock_out_irq3_pin_oe, 1'b0, "pin enable on battery");
    i_host.wr(`OFS_RAM_PAGE, 8'h80);
    wait_cyc(2);
    chk1(clock_out_irq3_pin_oe, 1'b1, "pin kept on battery");
    rdchk(`OFS_STD_FIRST | 8'h03, 8'hA0);
    i_host.wr(`OFS_RAM_PAGE, 8'h00);
    on_battery = 1'b0;
    clock_out_irq3_src = 1'b1;
    wait_cyc(4);
    chk1(clock_out_irq3_pin_o, 1'b1, "pin value back");
    $display("test pin done");
  endtask : t_pin

  task automatic t_batlow;
    rdchk(`OFS_THRESH_CTRL, 8'hF0);
    i_host.wr(`OFS_THRESH_CTRL, 8'h7A);
    rdchk(`OFS_THRESH_CTRL, 8'h70);
    chk8({4'h0, battery_threshold_select}, 8'h07, "threshold select");
    wait_cyc(4);
    pulse_clear();
    chk1(battery_low_flag, 1'b0, "flag clear above");
    vbat_above_ref = 1'b0;
    wait_cyc(4);
    chk1(battery_low_flag, 1'b1, "flag set below");
    vbat_above_ref = 1'b1;
    wait_cyc(4);
    pulse_clear();
    chk1(battery_low_flag, 1'b0, "flag cleared");
    i_host.wr(`OFS_RAM_PAGE, 8'h40);
    wait_cyc(3);
    chk1(battery_low_flag, 1'b1, "flag set above");
    pulse_clear();
    chk1(battery_low_flag, 1'b1, "flag stays while above");
    vbat_above_ref = 1'b0;
    wait_cyc(4);
    pulse_clear();
    chk1(battery_low_flag, 1'b0, "flag cleared below");
    $display("test battery low done");
  endtask : t_batlow

  // ==========================================
  // Verdict
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    rst_n = 1'b0;
    watchdog_input_pin = 1'b0;
    external_interrupt_pin = 1'b0;
    on_battery = 1'b0;
    vbat_above_ref = 1'b1;
    battery_low_clear = 1'b0;
    clock_out_irq3_src = 1'b1;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    t_ident();
    t_page();
    t_ram();
    t_pin();
    t_batlow();
    results();
  end
endmodule : tb_top
